// *** wdc_top.sv ***
// Notes on behaviour
// R01: on first enable the counter loads the stored reload value.
// R02: counter decrements once per watchdog tick unless refreshed.
// R03: refresh instruction reloads the counter; software must refresh in time.
// R04: while in debug mode the counter is refreshed every cycle.
// R05: reaching zero is a time-out.
// R06: time-out gives interrupt or reset per response-select option bit.
// R07: interrupt mode: pulse request to controller and set time-out flag.
// R08: after interrupt time-out counter wraps to all ones, no reload.
// R09: interrupt time-out in stop mode wakes the device and interrupts.
// R10: stop-mode interrupt time-out sets time-out flag and stop-wake flag.
// R11: reload value and counter are 24 bits wide.
module wdc_top #(
    parameter int CNT_W = wdc_pkg::CNT_W,
    parameter int TICK_DIV = wdc_pkg::TICK_DIV
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchdog_refresh_or_timeout_flag,
    input wire logic debug_mode,
    input wire logic stop_mode,
    input wire logic timeout_response_select,
    output logic irq_pulse,
    output logic wdt_reset,
    output logic stop_wake,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic refresh_s1_q;
    logic refresh_s2_q;
    logic debug_s1_q;
    logic debug_s2_q;
    logic stop_s1_q;
    logic stop_s2_q;
    logic resp_s1_q;
    logic resp_s2_q;
    logic resp_latched_q;
    logic resp_latched_d;
    logic resp_caught_q;
    logic resp_caught_d;

    always_comb
    begin
        resp_latched_d = resp_latched_q;
        resp_caught_d = 1'b1;
        if (!resp_caught_q)
        begin
            resp_latched_d = resp_s2_q;
        end
    end

    // option bit is non-volatile: caught once after reset, then held
    always_ff @(posedge clk)
    begin
        // option pin synced through reset so it is valid at release
        resp_s1_q <= timeout_response_select;
        resp_s2_q <= resp_s1_q;
        if (!resetn)
        begin
            refresh_s1_q <= 1'b0;
            refresh_s2_q <= 1'b0;
            debug_s1_q <= 1'b0;
            debug_s2_q <= 1'b0;
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
            resp_latched_q <= 1'b0;
            resp_caught_q <= 1'b0;
        end
        else
        begin
            refresh_s1_q <= watchdog_refresh_or_timeout_flag;
            refresh_s2_q <= refresh_s1_q;
            debug_s1_q <= debug_mode;
            debug_s2_q <= debug_s1_q;
            stop_s1_q <= stop_mode;
            stop_s2_q <= stop_s1_q;
            resp_latched_q <= resp_latched_d;
            resp_caught_q <= resp_caught_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    localparam int ST_W_L = wdc_pkg::ST_W;
    logic enable_q;
    logic enable_d;
    logic [CNT_W-1:0] reload_q;
    logic [CNT_W-1:0] reload_d;
    logic [ST_W_L-1:0] status_q;
    logic [ST_W_L-1:0] status_d;
    logic [ST_W_L-1:0] mask_q;
    logic [ST_W_L-1:0] mask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    ////////////////////////////////////////////////////////////////////////
    wdc_pkg::wdc_state_t state_q;
    wdc_pkg::wdc_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic irq_pulse_q;
    logic irq_pulse_d;
    logic wdt_reset_q;
    logic wdt_reset_d;
    logic wake_q;
    logic wake_d;
    logic timeout_ev;
    logic tick;
    logic refresh_ev;

    wdc_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(clk),
        .resetn(resetn),
        .run(state_q == wdc_pkg::WDC_RUN),
        .tick(tick)
    );

    // reload on every cycle the processor refresh is high, continuous reload in debug
    assign refresh_ev = refresh_s2_q | debug_s2_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        timeout_ev = 1'b0;
        irq_pulse_d = 1'b0;
        wdt_reset_d = 1'b0;
        wake_d = 1'b0;
        case (state_q)
            wdc_pkg::WDC_OFF:
            begin
                if (enable_q)
                begin
                    state_d = wdc_pkg::WDC_LOAD;
                end
            end
            wdc_pkg::WDC_LOAD:
            begin
                // R01 load on enable
                cnt_d = reload_q;
                state_d = wdc_pkg::WDC_RUN;
            end
            wdc_pkg::WDC_RUN:
            begin
                if (!enable_q)
                begin
                    state_d = wdc_pkg::WDC_OFF;
                end
                // R04 debug refresh
                // R03 refresh reload
                else if (refresh_ev)
                begin
                    cnt_d = reload_q;
                end
                else if (tick)
                begin
                    // R05 zero is time-out
                    if (cnt_q == wdc_pkg::CNT_ZERO)
                    begin
                        timeout_ev = 1'b1;
                        // R08 wrap to max
                        cnt_d = wdc_pkg::CNT_MAX;
                        // R06 response select
                        if (resp_latched_q)
                        begin
                            wdt_reset_d = 1'b1;
                        end
                        else
                        begin
                            // R07 interrupt request
                            irq_pulse_d = 1'b1;
                            // R09 stop recovery
                            wake_d = stop_s2_q;
                        end
                    end
                    else
                    begin
                        // R02 decrement
                        cnt_d = cnt_q - 24'h000001;
                    end
                end
            end
            default:
            begin
                state_d = wdc_pkg::WDC_OFF;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= wdc_pkg::WDC_OFF;
            cnt_q <= wdc_pkg::RELOAD_RST;
            irq_pulse_q <= 1'b0;
            wdt_reset_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            irq_pulse_q <= irq_pulse_d;
            wdt_reset_q <= wdt_reset_d;
            wake_q <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == wdc_pkg::ADDR_CTRL)
        | (paddr == wdc_pkg::ADDR_RELOAD)
        | (paddr == wdc_pkg::ADDR_STATUS)
        | (paddr == wdc_pkg::ADDR_MASK)
        | (paddr == wdc_pkg::ADDR_COUNT);

    always_comb
    begin
        enable_d = enable_q;
        reload_d = reload_q;
        mask_d = mask_q;
        status_d = status_q;
        prdata_d = prdata_q;
        if (wr_en)
        begin
            case (paddr)
                wdc_pkg::ADDR_CTRL:
                    enable_d = pwdata[wdc_pkg::CTRL_EN];
                wdc_pkg::ADDR_RELOAD:
                    reload_d = pwdata[CNT_W-1:0];
                wdc_pkg::ADDR_MASK:
                    mask_d = pwdata[ST_W_L-1:0];
                wdc_pkg::ADDR_STATUS:
                    status_d = status_q & ~pwdata[ST_W_L-1:0];
                default:
                    enable_d = enable_q;
            endcase
        end
        // set beats clear in the same cycle
        // R07 time-out flag
        if (irq_pulse_q)
        begin
            status_d[wdc_pkg::ST_TIMEOUT] = 1'b1;
        end
        // R10 stop flags
        if (wake_q)
        begin
            status_d[wdc_pkg::ST_STOPWAKE] = 1'b1;
        end
        if (rd_en)
        begin
            case (paddr)
                wdc_pkg::ADDR_CTRL:
                    prdata_d = {30'h0, resp_latched_q, enable_q};
                wdc_pkg::ADDR_RELOAD:
                    prdata_d = {8'h00, reload_q};
                wdc_pkg::ADDR_STATUS:
                    prdata_d = {30'h0, status_q};
                wdc_pkg::ADDR_MASK:
                    prdata_d = {30'h0, mask_q};
                wdc_pkg::ADDR_COUNT:
                    prdata_d = {8'h00, cnt_q};
                default:
                    prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            enable_q <= 1'b0;
            // R11 24-bit reload
            reload_q <= wdc_pkg::RELOAD_RST;
            status_q <= '0;
            mask_q <= '0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            enable_q <= enable_d;
            reload_q <= reload_d;
            status_q <= status_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_q;
    assign irq_pulse = irq_pulse_q;
    assign wdt_reset = wdt_reset_q;
    assign stop_wake = wake_q;
    assign irq = |(status_q & mask_q);
endmodule : wdc_top

// *** wdc_pkg.sv ***
package wdc_pkg;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] RELOAD_RST = 24'hffffff;
    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_RELOAD = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_MASK = 12'h00c;
    localparam logic [11:0] ADDR_COUNT = 12'h010;
    // ctrl fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_RES = 1;
    // status fields
    localparam int ST_TIMEOUT = 0;
    localparam int ST_STOPWAKE = 1;
    localparam int ST_W = 2;
    // watchdog tick period in system clocks
    localparam int TICK_DIV = 25000;
    typedef enum logic [1:0]
    {
        WDC_OFF = 2'b00,
        WDC_LOAD = 2'b01,
        WDC_RUN = 2'b11
    } wdc_state_t;
endpackage : wdc_pkg

// *** wdc_tick.sv ***
// divides the system clock down to one-cycle watchdog ticks
module wdc_tick #(
    parameter int DIV = wdc_pkg::TICK_DIV
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    output logic tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;
    logic tick_q;

    always_comb
    begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run)
        begin
            cnt_d = '0;
        end
        else if (cnt_q >= 32'(DIV - 1))
        begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : wdc_tick

// *** wdc_props.sv ***
module wdc_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic penable,
    input wire logic watchdog_refresh_or_timeout_flag,
    input wire logic debug_mode,
    input wire logic stop_mode,
    input wire logic timeout_response_select,
    input wire logic irq_pulse,
    input wire logic wdt_reset,
    input wire logic stop_wake,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_irq_single: assert property (irq_pulse |=> !irq_pulse)
        else $error("irq pulse longer than one cycle");
    a_irq_option: assert property (irq_pulse |-> !timeout_response_select)
        else $error("interrupt in reset response mode");
    a_rst_option: assert property (wdt_reset |-> timeout_response_select)
        else $error("reset in interrupt response mode");
    a_wake_irq: assert property (stop_wake |-> irq_pulse && stop_mode)
        else $error("wake without stop-mode interrupt");
    a_dbg_quiet: assert property (debug_mode [*8] |-> !irq_pulse)
        else $error("time-out while in debug mode");
    a_refresh_quiet:
        assert property (watchdog_refresh_or_timeout_flag [*8] |-> !irq_pulse)
        else $error("time-out while refresh held");
    // irq only rises after a pulse or a mask write
    a_irq_cause:
        assert property ($rose(irq) |-> $past(irq_pulse) || $past(penable))
        else $error("irq rose without cause");
    a_irq_sticky: assert property ($fell(irq) |-> $past(penable))
        else $error("irq dropped without a write");
endmodule : wdc_props

bind wdc_top wdc_props u_props (.*);

// *** wdc_cpu.sv ***
module wdc_cpu (
    input wire logic clk,
    input wire logic kick,
    input wire logic irq_pulse,
    input wire logic wdt_reset,
    input wire logic stop_wake,
    output logic refresh,
    output int n_irq,
    output int n_rst,
    output int n_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    initial refresh = 1'b0;
    always @(posedge clk)
        refresh <= kick;
    // single-cycle requests, so count every high cycle
    always @(posedge clk)
    begin
        n_irq <= n_irq + int'(irq_pulse);
        n_rst <= n_rst + int'(wdt_reset);
        n_wake <= n_wake + int'(stop_wake);
    end
endmodule : wdc_cpu

// *** wdc_tb_top.sv ***
module wdc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic kick = 1'b0;
    logic debug_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic timeout_response_select = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, refresh, irq_pulse, wdt_reset, stop_wake, irq, err;
    int n_irq, n_rst, n_wake, n_mismatch, num_checks, cyc;

    always #2 clk = ~clk;

    // short tick so time-outs land within tens of cycles
    wdc_top #(.TICK_DIV(4)) uut (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .watchdog_refresh_or_timeout_flag(refresh),
        .debug_mode, .stop_mode, .timeout_response_select, .irq_pulse,
        .wdt_reset, .stop_wake, .irq
    );
    wdc_cpu cpu (
        .clk, .kick, .irq_pulse, .wdt_reset, .stop_wake, .refresh, .n_irq,
        .n_rst, .n_wake
    );

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle cycle keeps back-to-back calls from re-driving psel at once
        @(posedge clk);
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdc

    task rst(input logic o);
        resetn <= 1'b0;
        timeout_response_select <= o;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : rst

    task wait_to;
        int s;
        s = n_irq + n_rst;
        for (int i = 0; i < 300 && n_irq + n_rst == s; i++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        chk(n_irq + n_rst - s, 1);
    endtask : wait_to

    task t_regs;
        rdc(12'h004, 32'h00ffffff);
        rdc(12'h020, 32'h00000000);
        chk(err, 1'b1);
        apb(1'b1, 12'h004, 32'h00000004);
        apb(1'b1, 12'h00c, 32'h00000003);
        apb(1'b1, 12'h000, 32'h00000001);
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd, 32'h00000004);
    endtask : t_regs

    task t_irq;
        wait_to;
        chk(irq, 1'b1);
        rdc(12'h008, 32'h00000001);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd >= 32'h00fffff0, 1'b1);
        apb(1'b1, 12'h00c, 32'h00000000);
        @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, 12'h00c, 32'h00000003);
        apb(1'b1, 12'h008, 32'h00000001);
        @(posedge clk);
        chk(irq, 1'b0);
    endtask : t_irq

    task t_refresh;
        int s;
        kick <= 1'b1;
        repeat (10) @(posedge clk);
        kick <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd <= 32'h00000004, 1'b1);
        s = n_irq;
        // refresh gap of 8 stays well under a 4-tick count
        repeat (12)
        begin
            kick <= 1'b1;
            @(posedge clk);
            kick <= 1'b0;
            repeat (7) @(posedge clk);
        end
        chk(n_irq, s);
    endtask : t_refresh

    task t_debug;
        int s;
        debug_mode <= 1'b1;
        s = n_irq;
        repeat (200) @(posedge clk);
        chk(n_irq, s);
        debug_mode <= 1'b0;
        wait_to;
        apb(1'b1, 12'h008, 32'h00000001);
    endtask : t_debug

    task t_stop;
        int w;
        w = n_wake;
        stop_mode <= 1'b1;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        wait_to;
        chk(n_wake - w, 1);
        rdc(12'h008, 32'h00000003);
        stop_mode <= 1'b0;
        apb(1'b1, 12'h008, 32'h00000003);
    endtask : t_stop

    task t_rstmode;
        int s;
        rst(1'b1);
        apb(1'b1, 12'h004, 32'h00000004);
        apb(1'b1, 12'h000, 32'h00000001);
        s = n_irq;
        wait_to;
        chk(n_irq, s);
        rdc(12'h000, 32'h00000003);
    endtask : t_rstmode

    initial
    begin
        rst(1'b0);
        t_regs;
        t_irq;
        t_refresh;
        t_debug;
        t_stop;
        t_rstmode;
        conclude;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            conclude;
        end
    end
endmodule : wdc_tb_top
